//--- rtl/core_memory_bus_pin_control.sv
// Purpose: pin-level control of the core's external memory bus
// Assumes: all pins synchronous to sys_clk; the rising-edge
//          sample instant is the last cycle of the data phase
// Notes:   tri-state pins are split into value and enable
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module core_memory_bus_pin_control #(
  parameter int ADDR_W = mem_pin_pkg::ADDR_W,
  parameter int DATA_W = mem_pin_pkg::DATA_W
) (
  input  wire logic              sys_clk,                   // Main clock
  input  wire logic              rst,                       // Sync reset
  input  wire logic              clk_en,                    // Freeze when low
  // Core side
  input  wire logic              core_req,                  // Start access
  input  wire logic [ADDR_W-1:0] core_addr,                 // Request address
  input  wire logic              core_atomic,               // Locked access
  input  wire logic [1:0]        core_size,                 // Request size
  input  wire logic              core_write,                // High for write
  input  wire logic              core_fetch,                // Instruction fetch
  input  wire logic              core_priv,                 // Privileged
  input  wire logic [DATA_W-1:0] core_wdata,                // Write data
  output      logic              core_busy,                 // Access running
  output      logic [DATA_W-1:0] core_rdata,                // Read result
  output      logic              core_rvalid,               // Read done pulse
  output      logic              core_abort,                // Denied pulse
  // Address and control pins
  input  wire logic              address_drive_enable,      // Float when low
  input  wire logic              address_hold_latch_n,      // Hold when low
  input  wire logic              address_pipeline_select,   // High pipelined
  input  wire logic              byte_order_select,         // High big-endian
  output      logic [ADDR_W-1:0] addr_out,                  // Address value
  output      logic              addr_oe,                   // Address drive
  output      logic              atomic_flag,               // Locked access
  output      logic [1:0]        access_size,               // Size pins
  output      logic              write_not_read,            // High write
  output      logic              instr_fetch_n,             // Low on fetch
  output      logic              privileged_access,         // High privileged
  output      logic              ctrl_oe,                   // Control drive
  // Data pins
  input  wire logic [3:0]        data_byte_capture_enables, // Lane capture
  input  wire logic              split_data_bus_select,     // Bus mode strap
  input  wire logic              data_drive_enable,         // Data drive gate
  input  wire logic              access_denied,             // Memory denial
  input  wire logic [DATA_W-1:0] data_in,                   // Shared bus in
  output      logic [DATA_W-1:0] data_out,                  // Shared bus out
  output      logic              data_oe,                   // Shared bus drive
  input  wire logic [DATA_W-1:0] read_data_in,              // Split read bus
  output      logic [DATA_W-1:0] write_data_out,            // Split write bus
  // Scan
  input  wire logic              test_clk_fall,             // Test clock fall
  input  wire logic              scan_intest,               // INTEST selected
  input  wire logic [3:0]        scan_chain_sel,            // Chain number
  output      logic              scan_bus_disable           // Float request
);

  initial begin
    if (ADDR_W != 32) $error("core_memory_bus_pin_control: ADDR_W must be 32");
    if (DATA_W != 32) $error("core_memory_bus_pin_control: DATA_W must be 32");
  end

  // ==========================================
  // State
  typedef struct packed {
    mem_pin_pkg::bus_state_t st;     // Sequencer
    logic [ADDR_W-1:0] s_addr;       // Staged request
    logic              s_atomic;
    logic [1:0]        s_size;
    logic              s_write;
    logic              s_fetch;
    logic              s_priv;
    logic [DATA_W-1:0] s_wdata;
    logic [ADDR_W-1:0] p_addr;       // Values on the pins
    logic              p_atomic;
    logic [1:0]        p_size;
    logic              p_write;
    logic              p_fetch;
    logic              p_priv;
    logic [DATA_W-1:0] cap;          // Captured read word
    logic              rvalid;       // Read done
    logic              abort;        // Denial seen
    logic              strap_taken;  // Bus mode caught
    logic              split;        // Caught bus mode
    logic              bus_dis;      // Scan float request
  } state_t;

  state_t q;                         // Registered state
  state_t d;                         // Next state

  logic [DATA_W-1:0] rd_src;         // Read bus in use
  logic [DATA_W-1:0] steered;        // Read value for the core
  logic [DATA_W-1:0] wr_word;        // Write data on lanes
  logic              wr_phase;       // Write data phase
  logic              rd_sample;      // Read sample instant

  // ==========================================
  // Decode of the scan chains that float the bus
  function automatic logic chain_floats(input logic [3:0] c);
    chain_floats = (c == mem_pin_pkg::CHAIN_A) ||
                   (c == mem_pin_pkg::CHAIN_B) ||
                   (c == mem_pin_pkg::CHAIN_C);
  endfunction

  // ==========================================
  // Write data replicated onto lanes for sub-word writes
  always_comb begin
    wr_word = q.s_wdata;
    if (q.s_size == mem_pin_pkg::SIZE_BYTE) begin
      wr_word = {4{q.s_wdata[7:0]}};
    end else if (q.s_size == mem_pin_pkg::SIZE_HALF) begin
      wr_word = {2{q.s_wdata[15:0]}};
    end
  end

  // Input bus choice follows the caught strap, not the live pin
  assign rd_src    = q.split ? read_data_in : data_in;
  assign wr_phase  = (q.st == mem_pin_pkg::ST_DATA) && q.s_write;
  assign rd_sample = (q.st == mem_pin_pkg::ST_DATA) && !q.s_write && clk_en;

  // ==========================================
  // Next state
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.abort  = 1'b0;
    if (clk_en) begin
      // Strap caught once; later changes are ignored on purpose
      if (!q.strap_taken) begin
        d.strap_taken = 1'b1;
        d.split       = split_data_bus_select;
      end
      // Sequencer; a new request may follow the data phase directly
      case (q.st)
        mem_pin_pkg::ST_IDLE: begin
          if (core_req) d.st = mem_pin_pkg::ST_ADDR;
        end
        mem_pin_pkg::ST_ADDR: begin
          d.st = mem_pin_pkg::ST_DATA;
        end
        mem_pin_pkg::ST_DATA: begin
          d.st = core_req ? mem_pin_pkg::ST_ADDR : mem_pin_pkg::ST_IDLE;
        end
        default: begin
          d.st = mem_pin_pkg::ST_IDLE;
        end
      endcase
      // Stage the request when accepted
      if (core_req && (q.st != mem_pin_pkg::ST_ADDR)) begin
        d.s_addr   = core_addr;
        d.s_atomic = core_atomic;
        d.s_size   = core_size;
        d.s_write  = core_write;
        d.s_fetch  = core_fetch;
        d.s_priv   = core_priv;
        d.s_wdata  = core_wdata;
      end
      // Pin values move only while the latch is open
      if (address_hold_latch_n) begin
        if (address_pipeline_select) begin
          // Early: pins show the request in the address phase
          if (core_req && (q.st != mem_pin_pkg::ST_ADDR)) begin
            d.p_addr   = core_addr;
            d.p_atomic = core_atomic;
            d.p_size   = core_size;
            d.p_write  = core_write;
            d.p_fetch  = core_fetch;
            d.p_priv   = core_priv;
          end
        end else if (q.st == mem_pin_pkg::ST_ADDR) begin
          // Late: pins load at the data phase and hold through it
          d.p_addr   = q.s_addr;
          d.p_atomic = q.s_atomic;
          d.p_size   = q.s_size;
          d.p_write  = q.s_write;
          d.p_fetch  = q.s_fetch;
          d.p_priv   = q.s_priv;
        end
      end
      // Capture enabled lanes at the read sample instant
      if (rd_sample) begin
        for (int i = 0; i < mem_pin_pkg::LANES; i++) begin
          if (data_byte_capture_enables[i]) begin
            d.cap[i*8 +: 8] = rd_src[i*8 +: 8];
          end
        end
        d.rvalid = 1'b1;
        d.abort  = access_denied;
      end
      // Scan float request follows the test clock fall
      if (test_clk_fall) begin
        d.bus_dis = scan_intest && chain_floats(scan_chain_sel);
      end
    end else begin
      d.rvalid = q.rvalid;
      d.abort  = q.abort;
    end
  end

  // ==========================================
  // Register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q.st          <= mem_pin_pkg::ST_IDLE;
      q.s_addr      <= mem_pin_pkg::ZERO_WORD;
      q.s_atomic    <= mem_pin_pkg::RST_BIT;
      q.s_size      <= mem_pin_pkg::SIZE_WORD;
      q.s_write     <= mem_pin_pkg::RST_BIT;
      q.s_fetch     <= mem_pin_pkg::RST_BIT;
      q.s_priv      <= mem_pin_pkg::RST_BIT;
      q.s_wdata     <= mem_pin_pkg::ZERO_WORD;
      q.p_addr      <= mem_pin_pkg::ZERO_WORD;
      q.p_atomic    <= mem_pin_pkg::RST_BIT;
      q.p_size      <= mem_pin_pkg::SIZE_WORD;
      q.p_write     <= mem_pin_pkg::RST_BIT;
      q.p_fetch     <= mem_pin_pkg::RST_BIT;
      q.p_priv      <= mem_pin_pkg::RST_BIT;
      q.cap         <= mem_pin_pkg::ZERO_WORD;
      q.rvalid      <= mem_pin_pkg::RST_BIT;
      q.abort       <= mem_pin_pkg::RST_BIT;
      q.strap_taken <= mem_pin_pkg::RST_BIT;
      q.split       <= mem_pin_pkg::RST_BIT;
      q.bus_dis     <= mem_pin_pkg::RST_BIT;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // Read steering by size and byte order
  byte_lane_steer #(
    .DATA_W (DATA_W)
  ) u_steer (
    .word    (q.cap),
    .size    (q.s_size),
    .addr_lo (q.s_addr[1:0]),
    .big_end (byte_order_select),
    .result  (steered)
  );

  // ==========================================
  // Outputs
  assign core_busy         = (q.st != mem_pin_pkg::ST_IDLE);
  assign core_rdata        = steered;
  assign core_rvalid       = q.rvalid;
  assign core_abort        = q.abort;
  assign addr_out          = q.p_addr;
  assign addr_oe           = address_drive_enable;
  assign ctrl_oe           = address_drive_enable;
  assign atomic_flag       = q.p_atomic;
  assign access_size       = q.p_size;
  assign write_not_read    = q.p_write;
  assign instr_fetch_n     = ~q.p_fetch;
  assign privileged_access = q.p_priv;
  // Shared bus driven only for writes in shared mode, gated by enable
  assign data_out          = wr_word;
  assign data_oe           = !q.split && wr_phase && data_drive_enable;
  // Split write bus reads zero whenever it carries no write
  assign write_data_out    = (q.split && wr_phase && data_drive_enable)
                             ? wr_word : mem_pin_pkg::ZERO_WORD;
  assign scan_bus_disable  = q.bus_dis;

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_addr_float;
    !address_drive_enable |-> (!addr_oe && !ctrl_oe);
  endproperty
  a_addr_float: assert property (p_addr_float)
    else $error("address driven while drive enable low");

  property p_latch_hold;
    (!address_hold_latch_n && clk_en) |=> $stable(addr_out) && $stable(access_size);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("address moved while latch held");

  property p_pipe_early;
    (clk_en && address_hold_latch_n && address_pipeline_select && core_req &&
     q.st != mem_pin_pkg::ST_ADDR) |=> (addr_out == $past(core_addr));
  endproperty
  a_pipe_early: assert property (p_pipe_early)
    else $error("pipelined address not issued early");

  property p_depipe_stable;
    (clk_en && !address_pipeline_select && q.st == mem_pin_pkg::ST_DATA)
      |=> $stable(addr_out) && $stable(write_not_read);
  endproperty
  a_depipe_stable: assert property (p_depipe_stable)
    else $error("depipelined address changed in data phase");

  property p_lane_keep;
    (rd_sample && !data_byte_capture_enables[0]) |=> $stable(q.cap[7:0]);
  endproperty
  a_lane_keep: assert property (p_lane_keep)
    else $error("disabled lane was captured");

  property p_shared_zero;
    !q.split |-> (write_data_out == mem_pin_pkg::ZERO_WORD);
  endproperty
  a_shared_zero: assert property (p_shared_zero)
    else $error("write bus not zero in shared mode");

  property p_split_float;
    q.split |-> !data_oe;
  endproperty
  a_split_float: assert property (p_split_float)
    else $error("shared bus driven in split mode");

  property p_dde_gate;
    !data_drive_enable |-> (!data_oe && write_data_out == mem_pin_pkg::ZERO_WORD);
  endproperty
  a_dde_gate: assert property (p_dde_gate)
    else $error("write data out while data enable low");

  property p_scan_dis;
    (clk_en && test_clk_fall) |=>
      (scan_bus_disable == ($past(scan_intest) && chain_floats($past(scan_chain_sel))));
  endproperty
  a_scan_dis: assert property (p_scan_dis)
    else $error("scan disable wrong after test clock fall");

  property p_strap_fixed;
    q.strap_taken |=> $stable(q.split);
  endproperty
  a_strap_fixed: assert property (p_strap_fixed)
    else $error("bus mode changed after strap caught");

  property p_abort_pulse;
    (rd_sample && access_denied) |=> core_abort && core_rvalid;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse)
    else $error("denial not reported with read");

  property p_split_read;
    (rd_sample && q.split && &data_byte_capture_enables) |=> (q.cap == $past(read_data_in));
  endproperty
  a_split_read: assert property (p_split_read)
    else $error("split read bus not captured");

  property p_shared_read;
    (rd_sample && !q.split && &data_byte_capture_enables) |=> (q.cap == $past(data_in));
  endproperty
  a_shared_read: assert property (p_shared_read)
    else $error("shared bus not captured in shared mode");

endmodule // core_memory_bus_pin_control

//--- rtl/mem_pin_pkg.sv
// Function
// - Drive 32-bit address under latch/enable/pipeline control
// - Address enable low floats address and controls
// - Latch low freezes address and control outputs
// - Pipeline select picks pipelined or depipelined timing
// - Pipelined timing issues address early
// - Depipelined timing holds address whole cycle
// - Byte order select picks big or little
// - Capture only enabled byte lanes at sample
// - Shared bus mode: write bus zero, ignore input
// - Split mode: use split buses, ignore shared
// - Scan disable high for INTEST chains 0/4/8
// - Split read bus sampled at read sample
// - Data drive enable gates both write outputs
//
// Purpose: constants for the memory bus pin control block
// Assumes: one clock, synchronous active-high reset
// Notes:   no registers; all control arrives on pins
package mem_pin_pkg;

  // ==========================================
  // Widths
  localparam int ADDR_W = 32;               // Address bus width
  localparam int DATA_W = 32;               // Data bus width
  localparam int LANES  = 4;                // Byte lanes

  // ==========================================
  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;  // 8-bit access
  localparam logic [1:0] SIZE_HALF = 2'h1;  // 16-bit access
  localparam logic [1:0] SIZE_WORD = 2'h2;  // 32-bit access

  // ==========================================
  // Scan chains that float the data bus under INTEST
  localparam logic [3:0] CHAIN_A = 4'h0;    // First chain
  localparam logic [3:0] CHAIN_B = 4'h4;    // Second chain
  localparam logic [3:0] CHAIN_C = 4'h8;    // Third chain

  // ==========================================
  // Reset values
  localparam logic [31:0] ZERO_WORD = 32'h0; // Cleared word
  localparam logic        RST_BIT   = 1'b0;  // Cleared flag

  // ==========================================
  // Bus cycle sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,                       // No access
    ST_ADDR = 3'b010,                       // Address phase
    ST_DATA = 3'b100                        // Data phase, sample at end
  } bus_state_t;

endpackage

//--- rtl/byte_lane_steer.sv
// Purpose: steer a read word to the core by size and byte order
// Assumes: word already captured from the enabled lanes
// Notes:   purely combinational; no state
`timescale 1ns/1ps
module byte_lane_steer #(
  parameter int DATA_W = 32
) (
  input  wire logic [DATA_W-1:0] word,       // Captured bus word
  input  wire logic [1:0]        size,       // Access size
  input  wire logic [1:0]        addr_lo,    // Low address bits
  input  wire logic              big_end,    // High for big-endian
  output      logic [DATA_W-1:0] result      // Zero-extended value
);

  initial begin
    if (DATA_W != 32) $error("byte_lane_steer: DATA_W must be 32");
  end

  // ==========================================
  // Lane index for a byte at this address
  function automatic logic [1:0] lane_of(input logic [1:0] a,
                                         input logic       be);
    lane_of = be ? ~a : a;
  endfunction

  // ==========================================
  // Select byte, half or word
  always_comb begin
    logic [1:0] lane;
    logic [1:0] hlane;
    lane   = 2'h0;
    hlane  = 2'h0;
    result = mem_pin_pkg::ZERO_WORD;
    lane   = lane_of(addr_lo, big_end);
    // Halfword lane: big-endian puts address 0 in the upper half
    hlane  = lane_of({addr_lo[1], 1'b0}, big_end) & 2'h2;
    if (size == mem_pin_pkg::SIZE_BYTE) begin
      result[7:0] = word[lane*8 +: 8];
    end else if (size == mem_pin_pkg::SIZE_HALF) begin
      result[15:0] = word[hlane*8 +: 16];
    end else begin
      result = word;
    end
  end

endmodule // byte_lane_steer

//--- sim/mem_side_model.sv
// Purpose: memory side model facing the bus pin control block
// Assumes: read word and refusal are set by the bench
// Notes:   a released bus shows a pattern that flips every cycle
`timescale 1ns/1ps
module mem_side_model (
  input  wire logic        sys_clk,        // Main clock
  input  wire logic        split,          // Board wiring: split buses
  input  wire logic        deny,           // Refuse reads
  input  wire logic [31:0] rd_word,        // Word returned on reads
  input  wire logic        ctrl_oe,        // Control pins driven
  input  wire logic        write_not_read, // High on writes
  input  wire logic [31:0] data_out,       // Shared bus value from device
  input  wire logic        data_oe,        // Shared bus drive from device
  output      logic [31:0] data_in,        // Shared bus level
  output      logic [31:0] read_data_in,   // Split read bus
  output      logic        access_denied   // Refusal pin
);
  // ==========================================
  // Released-bus pattern
  logic [31:0] float_q = 32'h5a5a5a5a; // Flips so a stale value never matches
  logic        reading;                // Device is reading

  // Pattern toggles every clock
  always @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  assign reading = ctrl_oe & ~write_not_read;
  // Device drive wins; shared bus unused when split
  assign data_in = data_oe ? data_out : (reading & ~split) ? rd_word : float_q;
  // Read bus tied low when unused
  assign read_data_in = split ? (reading ? rd_word : float_q) : 32'h0;
  assign access_denied = reading & deny;
endmodule // mem_side_model

//--- sim/core_memory_bus_pin_control_bench.sv
// Purpose: self-checking bench for the memory bus pin control block
// Assumes: memory model answers reads in the data phase
// Notes:   each access walks request, address, data, result cycles
`timescale 1ns/1ps
module core_memory_bus_pin_control_bench;
  // ==========================================
  // Pins and bench state
  logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, core_req = 1'b0, core_write = 1'b0;
  logic [31:0] core_addr = 32'h0, core_wdata = 32'h0;     // Request fields
  logic [1:0]  core_size = 2'h2;                           // Request size
  logic        address_drive_enable = 1'b1;                // High unless testing
  logic        address_hold_latch_n = 1'b1;                // High unless testing
  logic        address_pipeline_select = 1'b0, byte_order_select = 1'b0;
  logic [3:0]  data_byte_capture_enables = 4'hf;           // All lanes normally
  logic        split_data_bus_select = 1'b0, wired_split = 1'b0, data_drive_enable = 1'b1;
  logic        test_clk_fall = 1'b0, scan_intest = 1'b0;   // Scan inputs
  logic [3:0]  scan_chain_sel = 4'h0;                      // Scan chain
  logic        deny = 1'b0;                                // Memory refuses reads
  logic [31:0] rd_word = 32'h0, cap_q = 32'h0, last_pin = 32'h0; // Expected state
  int          err_count = 0, checks_done = 0, cyc = 0;    // Counters
  wire logic [31:0] core_rdata, addr_out, data_in, data_out, read_data_in, write_data_out;
  wire logic [1:0]  access_size;
  wire logic core_busy, core_rvalid, core_abort, addr_oe, atomic_flag, write_not_read;
  wire logic instr_fetch_n, privileged_access, ctrl_oe, access_denied, data_oe, scan_bus_disable;
  wire logic core_atomic = core_write;                     // Fields follow direction
  wire logic core_fetch  = ~core_write;
  wire logic core_priv   = ~core_write;

  core_memory_bus_pin_control uut (
    .sys_clk, .rst, .clk_en, .core_req, .core_addr, .core_atomic, .core_size, .core_write,
    .core_fetch, .core_priv, .core_wdata, .core_busy, .core_rdata, .core_rvalid, .core_abort,
    .address_drive_enable, .address_hold_latch_n, .address_pipeline_select, .byte_order_select,
    .addr_out, .addr_oe, .atomic_flag, .access_size, .write_not_read, .instr_fetch_n,
    .privileged_access, .ctrl_oe, .data_byte_capture_enables, .split_data_bus_select,
    .data_drive_enable, .access_denied, .data_in, .data_out, .data_oe, .read_data_in,
    .write_data_out, .test_clk_fall, .scan_intest, .scan_chain_sel, .scan_bus_disable);

  mem_side_model mem (.sys_clk, .split(wired_split), .deny, .rd_word, .ctrl_oe,
    .write_not_read, .data_out, .data_oe, .data_in, .read_data_in, .access_denied);

  // ==========================================
  // Clock and hang guard
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      finish_test();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Strap is sampled once, so reset is the only way to change bus mode
  task automatic do_reset(input logic s);
    rst <= 1'b1;
    split_data_bus_select <= s;
    wired_split <= s;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    last_pin = 32'h0;
    cap_q = 32'h0;
  endtask

  // Expected read value: lane picked by size, address and byte order
  function automatic logic [31:0] steer(input logic [31:0] w, input logic [1:0] a,
                                        input logic [1:0] sz, input logic be);
    logic [1:0] ln;
    ln = be ? ~a : a;
    if (sz == 2'h0) return {24'h0, w[8*ln +: 8]};
    if (sz == 2'h1) return {16'h0, w[16*ln[1] +: 16]};
    return w;
  endfunction

  // One access: checks pins in address and data cycles, result after
  task automatic access(input logic wr, input logic [31:0] a, input logic [1:0] sz,
                        input logic [31:0] wd);
    logic [31:0] pin, exp_w;
    exp_w = (sz == 2'h0) ? {4{wd[7:0]}} : (sz == 2'h1) ? {2{wd[15:0]}} : wd;
    @(posedge sys_clk);
    // Latch level read only after the caller's pending updates have landed
    pin = address_hold_latch_n ? a : last_pin;
    core_req <= 1'b1;
    core_write <= wr;
    core_addr <= a;
    core_size <= sz;
    core_wdata <= wd;
    @(posedge sys_clk);
    core_req <= 1'b0;
    #1 chk(addr_out, address_pipeline_select ? pin : last_pin);
    chk(32'(core_busy), 32'h1);
    @(posedge sys_clk);
    #1 chk(addr_out, pin);
    chk({26'h0, atomic_flag, access_size, write_not_read, instr_fetch_n, privileged_access},
        {26'h0, wr, sz, wr, wr, ~wr});
    chk(32'({addr_oe, ctrl_oe}), 32'({2{address_drive_enable}}));
    chk(32'(data_oe), 32'(~wired_split & wr & data_drive_enable));
    chk(write_data_out, (wired_split & wr & data_drive_enable) ? exp_w : 32'h0);
    if (~wired_split & wr & data_drive_enable) chk(data_out, exp_w);
    @(posedge sys_clk);
    #1 if (!wr) begin
      for (int i = 0; i < 4; i++) begin
        if (data_byte_capture_enables[i]) cap_q[8*i +: 8] = rd_word[8*i +: 8];
      end
    end
    chk(32'({core_rvalid, core_abort}), 32'({~wr, ~wr & deny}));
    if (!wr && !deny) chk(core_rdata, steer(cap_q, a[1:0], sz, byte_order_select));
    last_pin = pin;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset_vals();
    #1 chk({addr_out[29:0], access_size}, 32'h2);
    chk(32'({instr_fetch_n, scan_bus_disable, core_busy}), 32'h4);
    $display("reset test done");
  endtask

  // Both timings and both byte orders, each byte address offset once
  task automatic t_timing();
    for (int i = 0; i < 4; i++) begin
      address_pipeline_select <= i[0];
      byte_order_select <= i[1];
      rd_word <= 32'h44332211 + i;
      access(1'b0, 32'h1000 + i * 5, 2'h0, 32'h0);
    end
    access(1'b0, 32'h2002, 2'h1, 32'h0);
    $display("timing test done");
  endtask

  // Lanes with capture off keep the previous byte
  task automatic t_lanes();
    rd_word <= 32'h11223344;
    access(1'b0, 32'h3000, 2'h2, 32'h0);
    data_byte_capture_enables <= 4'ha;
    rd_word <= 32'haabbccdd;
    access(1'b0, 32'h3004, 2'h2, 32'h0);
    data_byte_capture_enables <= 4'hf;
    $display("lane test done");
  endtask

  // Writes with data drive off and on, byte and half sizes
  task automatic t_write();
    for (int i = 0; i < 4; i++) begin
      data_drive_enable <= i[0];
      access(1'b1, 32'h4000 + i * 4, {1'b0, i[1]}, 32'h8765c3a1 + i);
    end
    data_drive_enable <= 1'b1;
    $display("write test done");
  endtask

  task automatic t_deny();
    deny <= 1'b1;
    access(1'b0, 32'h5000, 2'h2, 32'h0);
    deny <= 1'b0;
    $display("deny test done");
  endtask

  // Latch low freezes the pins while an access runs
  task automatic t_latch();
    address_pipeline_select <= 1'b0;
    address_hold_latch_n <= 1'b0;
    rd_word <= 32'h0badf00d;
    access(1'b0, 32'h77770000, 2'h2, 32'h0);
    address_hold_latch_n <= 1'b1;
    $display("latch test done");
  endtask

  task automatic t_drive_en();
    address_drive_enable <= 1'b0;
    access(1'b1, 32'h6000, 2'h2, 32'h13572468);
    address_drive_enable <= 1'b1;
    $display("drive enable test done");
  endtask

  // Bus disable only for the scan chains named, on a test clock fall
  task automatic t_scan();
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      test_clk_fall <= (i != 5);
      scan_intest <= (i != 6);
      scan_chain_sel <= 4'(i * 2 % 12);
      @(posedge sys_clk);
      test_clk_fall <= 1'b0;
      #1 chk(32'(scan_bus_disable), 32'(i == 0 || i == 2 || i == 4 || i == 5));
    end
    $display("scan test done");
  endtask

  // Split buses; a live change of the strap pin is ignored
  task automatic t_split();
    do_reset(1'b1);
    rd_word <= 32'hfeedc0de;
    access(1'b0, 32'h8000, 2'h2, 32'h0);
    split_data_bus_select <= 1'b0;
    access(1'b1, 32'h8004, 2'h2, 32'h24681357);
    data_drive_enable <= 1'b0;
    access(1'b1, 32'h8008, 2'h1, 32'h0000beef);
    rd_word <= 32'h01020304;
    access(1'b0, 32'h800c, 2'h0, 32'h0);
    $display("split test done");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    do_reset(1'b0);
    t_reset_vals();
    t_timing();
    t_lanes();
    t_write();
    t_deny();
    t_latch();
    t_drive_en();
    t_scan();
    t_split();
    finish_test();
  end
endmodule // core_memory_bus_pin_control_bench
